// ===== logic/vif_pkg.sv
package vif_pkg;

  // ---------------------------------------------------------------
  // subaddresses
  // ---------------------------------------------------------------
  localparam logic [7:0] SUB_DELAY_TRIM = 8'h01;
  localparam logic [7:0] SUB_CTL_FIRST = 8'h02;
  localparam logic [7:0] SUB_CTL_SECOND = 8'h03;
  localparam logic [7:0] SUB_GAIN_ONE = 8'h04;
  localparam logic [7:0] SUB_GAIN_TWO = 8'h05;

  // ---------------------------------------------------------------
  // field codes
  // ---------------------------------------------------------------
  localparam logic [3:0] TRIM_NO_UPDATE = 4'hf;
  localparam logic [3:0] TRIM_MIN_DELAY = 4'he;
  localparam logic [3:0] TRIM_RECOMMENDED = 4'h8;
  localparam logic [3:0] TRIM_MAX_DELAY = 4'h0;
  localparam logic [1:0] ANALOG_FUNCTION_SELECT_AMP_ONLY = 2'h2;
  localparam logic [1:0] ANALOG_FUNCTION_SELECT_AMP_FILTER = 2'h3;
  localparam logic [3:0] MODE_CH1_LAST = 4'h1;
  localparam logic [3:0] MODE_COMPOSITE_VIDEO_LAST = 4'h5;
  localparam logic [3:0] MODE_YC_STATIC_LAST = 4'h7;
  localparam logic [3:0] MODE_YC_LAST = 4'h9;
  localparam logic [1:0] MODE_CH2_BASE = 2'h2;
  localparam logic [9:0] ACTIVE_LINE_60HZ = 10'h016;
  localparam logic [9:0] ACTIVE_LINE_50HZ = 10'h018;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [3:0] RST_TRIM = TRIM_RECOMMENDED;
  localparam logic [7:0] RST_CTL_FIRST = 8'h00;
  localparam logic [6:0] RST_CTL_SECOND = 7'h00;
  localparam logic [7:0] RST_GAIN_LOW = 8'h90;

  // ---------------------------------------------------------------
  // serial port
  // ---------------------------------------------------------------
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  // arbitrary neutral value
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2a;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0] analog_function_select;
    logic [1:0] gain_update_hysteresis;
    logic [3:0] input_mode;
  } vif_ctl1_t;

  typedef struct packed {
    logic clamp_reference_select;
    logic blanking_length_select;
    logic white_peak_disable;
    logic gain_hold;
    logic gain_fix;
    logic channel_two_gain_msb;
    logic channel_one_gain_msb;
  } vif_ctl2_t;

  typedef enum logic [1:0] {
    GAIN_AUTO = 2'b00,
    GAIN_STATIC = 2'b01,
    GAIN_FOLLOW = 2'b11
  } vif_gain_src_t;

  typedef struct packed {
    logic [3:0] delay_trim_field;
    logic amp_enable;
    logic filter_enable;
    logic ch1_active;
    logic ch1_input;
    logic ch2_active;
    logic [1:0] ch2_input;
    logic luma_chroma;
    vif_gain_src_t ch1_gain_src;
    vif_gain_src_t ch2_gain_src;
    logic [8:0] ch1_gain;
    logic [8:0] ch2_gain;
    logic clamp_reference_select;
    logic white_peak_enable;
    logic agc_freeze;
  } vif_fe_ctrl_t;

  typedef enum logic [3:0] {
    I2C_IDLE = 4'b0000,
    I2C_ADDR = 4'b0001,
    I2C_AACK = 4'b0011,
    I2C_SUB = 4'b0010,
    I2C_SACK = 4'b0110,
    I2C_WDAT = 4'b0111,
    I2C_WACK = 4'b0101,
    I2C_RDAT = 4'b0100,
    I2C_RACK = 4'b1100
  } vif_i2c_state_t;

  typedef struct packed {
    vif_i2c_state_t state;
    logic scl_q;
    logic sda_q;
    logic [7:0] shift;
    logic [3:0] cnt;
    logic rw;
    logic [7:0] sub;
    logic sda_oe;
    logic wr_stb;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
  } vif_i2c_reg_t;

  typedef struct packed {
    logic long_window;
    logic agc_disable;
  } vif_gate_reg_t;

endpackage : vif_pkg

// ===== logic/vif_i2c_slave.sv
`timescale 1ns/1ps
module vif_i2c_slave #(
  parameter logic [6:0] DEV_ADDR = vif_pkg::DEV_ADDR_DEFAULT
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_oe,
  output logic wr_stb,
  output logic [7:0] wr_addr,
  output logic [7:0] wr_data,
  output logic [7:0] rd_addr,
  input wire logic [7:0] rd_data
);
  import vif_pkg::*;

  if (DEV_ADDR[6:3] == 4'h0 || DEV_ADDR[6:3] == 4'hf)
  begin : g_bad_addr
    $error("device address lies in a reserved group");
  end

  vif_i2c_reg_t s;
  vif_i2c_reg_t next_s;
  logic rise;
  logic fall;
  logic start_c;
  logic stop_c;

  assign rise = !s.scl_q && scl_in;
  assign fall = s.scl_q && !scl_in;
  assign start_c = s.scl_q && scl_in && s.sda_q && !sda_in;
  assign stop_c = s.scl_q && scl_in && !s.sda_q && sda_in;

  // ---------------------------------------------------------------
  // byte engine
  // ---------------------------------------------------------------
  always_comb
  begin
    next_s = s;
    next_s.wr_stb = 1'b0;
    next_s.scl_q = scl_in;
    next_s.sda_q = sda_in;
    if (start_c)
    begin
      next_s.state = I2C_ADDR;
      next_s.cnt = 4'h0;
      next_s.sda_oe = 1'b0;
    end
    else if (stop_c)
    begin
      next_s.state = I2C_IDLE;
      next_s.sda_oe = 1'b0;
    end
    else
    begin
      case (s.state)
        I2C_ADDR, I2C_SUB, I2C_WDAT:
        begin
          if (rise && s.cnt < BITS_PER_BYTE)
          begin
            next_s.shift = {s.shift[6:0], sda_in};
            next_s.cnt = s.cnt + 4'h1;
          end
          if (fall && s.cnt == BITS_PER_BYTE)
          begin
            next_s.cnt = 4'h0;
            next_s.sda_oe = 1'b1;
            if (s.state == I2C_ADDR)
            begin
              next_s.rw = s.shift[0];
              next_s.state = I2C_AACK;
              if (s.shift[7:1] != DEV_ADDR)
              begin
                next_s.state = I2C_IDLE;
                next_s.sda_oe = 1'b0;
              end
            end
            else if (s.state == I2C_SUB)
            begin
              next_s.sub = s.shift;
              next_s.state = I2C_SACK;
            end
            else
            begin
              next_s.wr_stb = 1'b1; // [R17]
              next_s.wr_addr = s.sub;
              next_s.wr_data = s.shift;
              next_s.state = I2C_WACK;
            end
          end
        end
        I2C_AACK:
        begin
          if (fall)
          begin
            if (s.rw)
            begin
              next_s.shift = rd_data;
              next_s.sda_oe = !rd_data[7];
              next_s.sub = s.sub + 8'h01;
              next_s.cnt = 4'h1;
              next_s.state = I2C_RDAT;
            end
            else
            begin
              next_s.sda_oe = 1'b0;
              next_s.state = I2C_SUB;
            end
          end
        end
        I2C_SACK:
        begin
          if (fall)
          begin
            next_s.sda_oe = 1'b0;
            next_s.state = I2C_WDAT;
          end
        end
        I2C_WACK:
        begin
          if (fall)
          begin
            next_s.sda_oe = 1'b0;
            next_s.sub = s.sub + 8'h01;
            next_s.state = I2C_WDAT;
          end
        end
        I2C_RDAT:
        begin
          if (fall)
          begin
            if (s.cnt == BITS_PER_BYTE)
            begin
              next_s.sda_oe = 1'b0;
              next_s.cnt = 4'h0;
              next_s.state = I2C_RACK;
            end
            else
            begin
              next_s.sda_oe = !s.shift[6];
              next_s.shift = {s.shift[6:0], 1'b0};
              next_s.cnt = s.cnt + 4'h1;
            end
          end
        end
        I2C_RACK:
        begin
          if (rise)
          begin
            next_s.state = sda_in ? I2C_IDLE : I2C_AACK;
          end
        end
        default:
        begin
          next_s.state = I2C_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s <= '{state: I2C_IDLE, scl_q: 1'b1, sda_q: 1'b1, default: '0};
    end
    else
    begin
      s <= next_s;
    end
  end

  assign sda_oe = s.sda_oe;
  assign wr_stb = s.wr_stb;
  assign wr_addr = s.wr_addr;
  assign wr_data = s.wr_data;
  assign rd_addr = s.sub;

endmodule : vif_i2c_slave

// ===== logic/vif_agc_gate.sv
`timescale 1ns/1ps
module vif_agc_gate (
  input wire logic clk,
  input wire logic rst,
  input wire logic long_select,
  input wire logic eq_pulse_active,
  input wire logic pre_eq_start,
  input wire logic [9:0] line_number,
  input wire logic field_60hz,
  output logic agc_disable
);
  import vif_pkg::*;

  vif_gate_reg_t s;
  vif_gate_reg_t next_s;
  logic [9:0] end_line;

  // ---------------------------------------------------------------
  // blanking window
  // ---------------------------------------------------------------
  always_comb
  begin
    next_s = s;
    end_line = field_60hz ? ACTIVE_LINE_60HZ : ACTIVE_LINE_50HZ;
    if (pre_eq_start)
    begin
      next_s.long_window = 1'b1; // [R09]
    end
    else if (line_number == end_line)
    begin
      next_s.long_window = 1'b0; // [R09]
    end
    next_s.agc_disable = long_select ? next_s.long_window : eq_pulse_active; // [R09]
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign agc_disable = s.agc_disable;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_LONG_OPEN: assert property (long_select && pre_eq_start |=> agc_disable) // [R09]
    else $error("long blanking did not disable agc");
  AST_LONG_CLOSE: assert property (long_select && !pre_eq_start
    && line_number == (field_60hz ? ACTIVE_LINE_60HZ : ACTIVE_LINE_50HZ)
    |=> !agc_disable) // [R09]
    else $error("agc not released at active video line");
  AST_SHORT: assert property (!long_select |=> agc_disable == $past(eq_pulse_active)) // [R09]
    else $error("short blanking does not follow equalization pulses");

endmodule : vif_agc_gate

// ===== logic/vif_frontend_ctrl.sv
`timescale 1ns/1ps
// How it works
// R01 - trim code loads delay; all ones keeps
// R02 - function select: amp, amp plus filter, bypass
// R03 - modes 0-5: composite from one input
// R04 - modes 6,7: luma/chroma, chroma static gain
// R05 - modes 8,9: luma/chroma, chroma follows luma
// R06 - host avoids reserved modes 10 to 15
// R07 - host sets trap bypass for luma/chroma
// R08 - clamp reference select while unlocked
// R09 - blanking length picks agc disable window
// R10 - white peak disable bit turns control off
// R11 - gain hold freezes agc integrator
// R12 - gain fix selects static gain both channels
// R13 - host avoids clamp ref with white peak
// R14 - channel one static gain nine bits
// R15 - channel two static gain nine bits
// R16 - host writes zero to unused bits
// R17 - registers hold value until rewritten
module vif_frontend_ctrl #(
  parameter logic [6:0] DEV_ADDR = vif_pkg::DEV_ADDR_DEFAULT
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic eq_pulse_active,
  input wire logic pre_eq_start,
  input wire logic [9:0] line_number,
  input wire logic field_60hz,
  output vif_pkg::vif_fe_ctrl_t fe_ctrl,
  output logic agc_disable
);
  import vif_pkg::*;

  typedef struct packed {
    logic [3:0] trim;
    vif_ctl1_t ctl1;
    vif_ctl2_t ctl2;
    logic [7:0] gain1_low;
    logic [7:0] gain2_low;
    vif_fe_ctrl_t out;
  } vif_top_reg_t;

  vif_top_reg_t s;
  vif_top_reg_t next_s;
  logic wr_stb;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic is_composite_video(input logic [3:0] mode);
    is_composite_video = (mode <= MODE_COMPOSITE_VIDEO_LAST);
  endfunction : is_composite_video

  function automatic logic is_yc(input logic [3:0] mode);
    is_yc = (mode > MODE_COMPOSITE_VIDEO_LAST) && (mode <= MODE_YC_LAST);
  endfunction : is_yc

  function automatic logic [7:0] reg_read(input vif_top_reg_t r, input logic [7:0] a);
    case (a)
      SUB_DELAY_TRIM: reg_read = {4'h0, r.trim};
      SUB_CTL_FIRST: reg_read = r.ctl1;
      SUB_CTL_SECOND: reg_read = {1'b0, r.ctl2};
      SUB_GAIN_ONE: reg_read = r.gain1_low;
      SUB_GAIN_TWO: reg_read = r.gain2_low;
      default: reg_read = 8'h00;
    endcase
  endfunction : reg_read

  // ---------------------------------------------------------------
  // serial port and agc window
  // ---------------------------------------------------------------
  vif_i2c_slave #(
    .DEV_ADDR(DEV_ADDR)
  ) u_port (
    .clk(clk),
    .rst(rst),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_oe(sda_oe),
    .wr_stb(wr_stb),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  vif_agc_gate u_gate (
    .clk(clk),
    .rst(rst),
    .long_select(s.ctl2.blanking_length_select),
    .eq_pulse_active(eq_pulse_active),
    .pre_eq_start(pre_eq_start),
    .line_number(line_number),
    .field_60hz(field_60hz),
    .agc_disable(agc_disable)
  );

  assign rd_data = reg_read(s, rd_addr);
  assign sda_out = 1'b0;

  // ---------------------------------------------------------------
  // registers and routing
  // ---------------------------------------------------------------
  always_comb
  begin
    next_s = s;
    if (wr_stb)
    begin
      case (wr_addr)
        SUB_DELAY_TRIM: next_s.trim = wr_data[3:0]; // [R17]
        SUB_CTL_FIRST: next_s.ctl1 = wr_data; // [R17]
        SUB_CTL_SECOND: next_s.ctl2 = wr_data[6:0]; // [R17]
        SUB_GAIN_ONE: next_s.gain1_low = wr_data; // [R14]
        SUB_GAIN_TWO: next_s.gain2_low = wr_data; // [R15]
        default: ;
      endcase
    end
    if (s.trim != TRIM_NO_UPDATE)
    begin
      next_s.out.delay_trim_field = s.trim; // [R01]
    end
    next_s.out.amp_enable = s.ctl1.analog_function_select[1]; // [R02]
    next_s.out.filter_enable = (s.ctl1.analog_function_select == ANALOG_FUNCTION_SELECT_AMP_FILTER); // [R02]
    if (is_composite_video(s.ctl1.input_mode))
    begin
      next_s.out.luma_chroma = 1'b0; // [R03]
      next_s.out.ch1_active = (s.ctl1.input_mode <= MODE_CH1_LAST);
      next_s.out.ch1_input = s.ctl1.input_mode[0];
      next_s.out.ch2_active = (s.ctl1.input_mode > MODE_CH1_LAST);
      next_s.out.ch2_input = s.ctl1.input_mode[1:0] - MODE_CH2_BASE;
      next_s.out.ch1_gain_src = GAIN_AUTO;
      next_s.out.ch2_gain_src = GAIN_AUTO;
    end
    else if (is_yc(s.ctl1.input_mode))
    begin
      next_s.out.luma_chroma = 1'b1;
      next_s.out.ch1_active = 1'b1;
      next_s.out.ch2_active = 1'b1;
      next_s.out.ch1_input = s.ctl1.input_mode[0];
      next_s.out.ch2_input = {1'b0, s.ctl1.input_mode[0]};
      next_s.out.ch1_gain_src = GAIN_AUTO;
      if (s.ctl1.input_mode <= MODE_YC_STATIC_LAST)
      begin
        next_s.out.ch2_gain_src = GAIN_STATIC; // [R04]
      end
      else
      begin
        next_s.out.ch2_gain_src = GAIN_FOLLOW; // [R05]
      end
    end
    if (s.ctl2.gain_fix)
    begin
      next_s.out.ch1_gain_src = GAIN_STATIC; // [R12]
      next_s.out.ch2_gain_src = GAIN_STATIC; // [R12]
    end
    next_s.out.ch1_gain = {s.ctl2.channel_one_gain_msb, s.gain1_low}; // [R14]
    next_s.out.ch2_gain = {s.ctl2.channel_two_gain_msb, s.gain2_low}; // [R15]
    next_s.out.clamp_reference_select = s.ctl2.clamp_reference_select; // [R08]
    next_s.out.white_peak_enable = !s.ctl2.white_peak_disable; // [R10]
    next_s.out.agc_freeze = s.ctl2.gain_hold; // [R11]
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s <= '{trim: RST_TRIM, ctl1: RST_CTL_FIRST, ctl2: RST_CTL_SECOND,
             gain1_low: RST_GAIN_LOW, gain2_low: RST_GAIN_LOW,
             out: '{delay_trim_field: RST_TRIM, ch1_active: 1'b1,
                    ch1_gain_src: GAIN_AUTO, ch2_gain_src: GAIN_AUTO,
                    ch1_gain: {1'b0, RST_GAIN_LOW}, ch2_gain: {1'b0, RST_GAIN_LOW},
                    white_peak_enable: 1'b1, default: '0}};
    end
    else
    begin
      s <= next_s;
    end
  end

  assign fe_ctrl = s.out;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_gain1_write;
    wr_stb && wr_addr == SUB_GAIN_ONE ##1 !wr_stb;
  endsequence

  sequence s_gain2_write;
    wr_stb && wr_addr == SUB_GAIN_TWO ##1 !wr_stb;
  endsequence

  AST_WRITE_CTL1: assert property (wr_stb && wr_addr == SUB_CTL_FIRST
    |=> s.ctl1 == $past(wr_data)) // [R17]
    else $error("control register one not loaded");
  AST_HOLD_CTL2: assert property (!(wr_stb && wr_addr == SUB_CTL_SECOND)
    |=> $stable(s.ctl2)) // [R17]
    else $error("control register two changed without write");
  AST_TRIM_KEEP: assert property (s.trim == TRIM_NO_UPDATE
    |=> $stable(fe_ctrl.delay_trim_field)) // [R01]
    else $error("delay moved on no-update code");
  AST_TRIM_LOAD: assert property (s.trim != TRIM_NO_UPDATE
    |=> fe_ctrl.delay_trim_field == $past(s.trim)) // [R01]
    else $error("delay trim not applied");
  AST_ANALOG_FUNCTION_SELECT_BYPASS: assert property (!s.ctl1.analog_function_select[1]
    |=> !fe_ctrl.amp_enable && !fe_ctrl.filter_enable) // [R02]
    else $error("bypass code left amplifier on");
  AST_ANALOG_FUNCTION_SELECT_AMP: assert property (s.ctl1.analog_function_select == ANALOG_FUNCTION_SELECT_AMP_ONLY
    |=> fe_ctrl.amp_enable && !fe_ctrl.filter_enable) // [R02]
    else $error("amplifier-only code wrong");
  AST_COMPOSITE_VIDEO_CH1: assert property (s.ctl1.input_mode <= MODE_CH1_LAST && !s.ctl2.gain_fix
    |=> fe_ctrl.ch1_active && !fe_ctrl.ch2_active && !fe_ctrl.luma_chroma
    && fe_ctrl.ch1_input == $past(s.ctl1.input_mode[0])
    && fe_ctrl.ch1_gain_src == GAIN_AUTO) // [R03]
    else $error("composite channel one routing wrong");
  AST_COMPOSITE_VIDEO_CH2: assert property (s.ctl1.input_mode > MODE_CH1_LAST
    && s.ctl1.input_mode <= MODE_COMPOSITE_VIDEO_LAST
    |=> fe_ctrl.ch2_active && !fe_ctrl.ch1_active
    && fe_ctrl.ch2_input == $past(s.ctl1.input_mode[1:0]) - MODE_CH2_BASE) // [R03]
    else $error("composite channel two routing wrong");
  AST_YC_STATIC: assert property (is_yc(s.ctl1.input_mode)
    && s.ctl1.input_mode <= MODE_YC_STATIC_LAST
    |=> fe_ctrl.luma_chroma && fe_ctrl.ch2_gain_src == GAIN_STATIC
    && {1'b0, fe_ctrl.ch1_input} == fe_ctrl.ch2_input) // [R04]
    else $error("luma/chroma static chroma gain wrong");
  AST_YC_FOLLOW: assert property (s.ctl1.input_mode > MODE_YC_STATIC_LAST
    && s.ctl1.input_mode <= MODE_YC_LAST && !s.ctl2.gain_fix
    |=> fe_ctrl.luma_chroma && fe_ctrl.ch2_gain_src == GAIN_FOLLOW) // [R05]
    else $error("chroma gain does not follow luma");
  AST_CLAMP: assert property (1'b1
    |=> fe_ctrl.clamp_reference_select == $past(s.ctl2.clamp_reference_select)) // [R08]
    else $error("clamp reference select not passed");
  AST_WPEAK: assert property (s.ctl2.white_peak_disable |=> !fe_ctrl.white_peak_enable) // [R10]
    else $error("white peak still enabled");
  AST_FREEZE: assert property (s.ctl2.gain_hold |=> fe_ctrl.agc_freeze) // [R11]
    else $error("integrator not frozen");
  AST_FIX: assert property (s.ctl2.gain_fix
    |=> fe_ctrl.ch1_gain_src == GAIN_STATIC && fe_ctrl.ch2_gain_src == GAIN_STATIC) // [R12]
    else $error("gain fix not applied to both channels");
  AST_GAIN1: assert property (s_gain1_write
    |=> fe_ctrl.ch1_gain == {s.ctl2.channel_one_gain_msb, $past(wr_data, 2)}) // [R14]
    else $error("channel one gain not assembled");
  AST_GAIN2: assert property (s_gain2_write
    |=> fe_ctrl.ch2_gain == {s.ctl2.channel_two_gain_msb, $past(wr_data, 2)}) // [R15]
    else $error("channel two gain not assembled");
  AST_ANALOG_FUNCTION_SELECT_FILTER: assert property (s.ctl1.analog_function_select == ANALOG_FUNCTION_SELECT_AMP_FILTER
    |=> fe_ctrl.amp_enable && fe_ctrl.filter_enable) // [R02]
    else $error("amplifier plus filter code wrong");
  AST_WRITE_CTL2: assert property (wr_stb && wr_addr == SUB_CTL_SECOND
    |=> s.ctl2 == $past(wr_data[6:0])) // [R17]
    else $error("control register two not loaded");
  AST_HOLD_TRIM: assert property (!(wr_stb && wr_addr == SUB_DELAY_TRIM)
    |=> $stable(s.trim)) // [R17]
    else $error("trim register changed without write");
  AST_HOLD_GAIN1: assert property (!(wr_stb && wr_addr == SUB_GAIN_ONE)
    |=> $stable(s.gain1_low)) // [R17]
    else $error("gain one register changed without write");

endmodule : vif_frontend_ctrl

// ===== test/vif_host_model.sv
`timescale 1ns/1ps
module vif_host_model
  import vif_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT,
  parameter int QTR = 4
) (
  input wire logic clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_pull
);
  // ---------------------------------------------------------------
  // serial host, bus idles high through pull-up
  // ---------------------------------------------------------------
  initial
  begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic wait_q(input int n);
    repeat (n * QTR) @(negedge clk);
  endtask : wait_q

  task automatic xfer_bit(input logic b, output logic got);
    sda_pull = ~b;
    wait_q(1);
    scl = 1'b1;
    wait_q(1);
    got = sda_line;
    wait_q(1);
    scl = 1'b0;
    wait_q(1);
  endtask : xfer_bit

  task automatic xfer_byte(input logic [7:0] d, output logic [7:0] got, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--)
    begin
      xfer_bit(d[i], got[i]);
    end
    xfer_bit(1'b1, a);
    ack = ~a;
  endtask : xfer_byte

  task automatic do_start;
    sda_pull = 1'b0;
    wait_q(1);
    scl = 1'b1;
    wait_q(1);
    sda_pull = 1'b1;
    wait_q(1);
    scl = 1'b0;
    wait_q(1);
  endtask : do_start

  task automatic do_stop;
    sda_pull = 1'b1;
    wait_q(1);
    scl = 1'b1;
    wait_q(1);
    sda_pull = 1'b0;
    wait_q(2);
  endtask : do_stop

  task automatic write_regs(input logic [7:0] sub, input logic [23:0] data, input int n,
                            output logic ok);
    logic [7:0] g;
    logic a;
    do_start();
    xfer_byte({DEV_ADDR, 1'b0}, g, ok);
    xfer_byte(sub, g, a);
    ok = ok & a;
    for (int k = 0; k < n; k++)
    begin
      xfer_byte(data[23 - 8 * k -: 8], g, a);
      ok = ok & a;
    end
    do_stop();
  endtask : write_regs

  task automatic read_reg(input logic [7:0] sub, output logic [7:0] d, output logic ok);
    logic [7:0] g;
    logic a;
    do_start();
    xfer_byte({DEV_ADDR, 1'b0}, g, ok);
    xfer_byte(sub, g, a);
    ok = ok & a;
    do_start();
    xfer_byte({DEV_ADDR, 1'b1}, g, a);
    ok = ok & a;
    // ninth bit left released: single byte then not-acknowledge
    xfer_byte(8'hff, d, a);
    do_stop();
  endtask : read_reg
endmodule : vif_host_model

// ===== test/video_input_frontend_control_test.sv
`timescale 1ns/1ps
module video_input_frontend_control_test;
  import vif_pkg::*;
  logic clk, rst, scl, host_pull, sda_out, sda_oe, eq_pulse, pre_eq, f60, agc_disable, ack;
  logic [9:0] line_no;
  logic [7:0] rd;
  vif_fe_ctrl_t fe;
  wire logic sda_line = ~((sda_oe & ~sda_out) | host_pull);
  int n_mismatch = 0;
  int checked = 0;
  int cycles = 0;
  localparam logic [39:0] RST_REGS = 40'h0800009090;

  vif_frontend_ctrl dut_u (.clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .eq_pulse_active(eq_pulse), .pre_eq_start(pre_eq),
    .line_number(line_no), .field_60hz(f60), .fe_ctrl(fe), .agc_disable(agc_disable));
  vif_host_model host_u (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_pull(host_pull));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // compare, access and closing tasks
  // ---------------------------------------------------------------
  task automatic chk_val(input logic [8:0] got, input logic [8:0] exp, input string msg);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask : chk_val

  task automatic chk_reg(input logic [7:0] sub, input logic [7:0] exp);
    host_u.read_reg(sub, rd, ack);
    chk_val({ack, rd}, {1'b1, exp}, "register read");
  endtask : chk_reg

  task automatic wr(input logic [7:0] sub, input logic [7:0] data);
    host_u.write_regs(sub, {data, 16'h0000}, 1, ack);
    chk_val(9'(ack), 9'h001, "write ack");
  endtask : wr

  task automatic complete_run;
    $display("mismatches %0d comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      n_mismatch++;
      complete_run();
    end
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    rst = 1'b1;
    eq_pulse = 1'b0;
    pre_eq = 1'b0;
    f60 = 1'b0;
    line_no = 10'h000;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    chk_val(9'(fe.delay_trim_field), 9'h008, "trim reset");
    chk_val(fe.ch1_gain, 9'h090, "gain one reset");
    chk_val(fe.ch2_gain, 9'h090, "gain two reset");
    chk_val(9'(fe.white_peak_enable), 9'h001, "white peak reset");
    for (int k = 1; k <= 5; k++)
    begin
      chk_reg(8'(k), RST_REGS[8 * (5 - k) +: 8]);
    end
    for (int i = 0; i < 4; i++)
    begin
      wr(SUB_DELAY_TRIM, {4'h0, 4'(16'hef80 >> (12 - 4 * i))});
      chk_val(9'(fe.delay_trim_field), 9'((16'hee80 >> (12 - 4 * i)) & 4'hf), "trim");
    end
    for (int i = 0; i < 4; i++)
    begin
      wr(SUB_CTL_FIRST, {2'(i), 6'h00});
      chk_val(9'({fe.amp_enable, fe.filter_enable}), 9'(i[1] ? {1'b1, i[0]} : 2'b00),
        "function select");
    end
    // modes 0 to 9 only, reserved codes never sent
    for (int m = 0; m < 10; m++)
    begin
      wr(SUB_CTL_FIRST, {4'h0, 4'(m)});
      chk_val(9'(fe.ch1_gain_src), 9'(GAIN_AUTO), "luma gain source");
      if (m < 2)
        chk_val(9'({fe.ch1_active, fe.ch1_input, fe.ch2_active, fe.luma_chroma}),
          9'({1'b1, m[0], 2'b00}), "composite one");
      else if (m < 6)
        chk_val(9'({fe.ch1_active, fe.ch2_active, fe.ch2_input, fe.luma_chroma, fe.ch2_gain_src}),
          9'({2'b01, 2'(m - 2), 1'b0, GAIN_AUTO}), "composite two");
      else
        chk_val(9'({fe.ch1_active, fe.ch1_input, fe.ch2_active, fe.ch2_input, fe.luma_chroma,
          fe.ch2_gain_src}), 9'({1'b1, m[0], 2'b10, m[0], 1'b1, (m < 8) ? 2'b01 : 2'b11}),
          "luma chroma");
    end
    wr(8'h09, 8'h80);
    chk_reg(8'h09, 8'h00);
    // clamp reference only with white peak off
    host_u.write_regs(SUB_CTL_SECOND, 24'h5dff00, 3, ack);
    chk_val(9'(ack), 9'h001, "burst ack");
    chk_val(fe.ch1_gain, 9'h1ff, "gain one max");
    chk_val(fe.ch2_gain, 9'h000, "gain two min");
    chk_val(9'({fe.clamp_reference_select, fe.white_peak_enable, fe.agc_freeze}), 9'h005,
      "control bits set");
    chk_val(9'({fe.ch1_gain_src, fe.ch2_gain_src}), 9'h005, "gain fix");
    chk_reg(SUB_CTL_SECOND, 8'h5d);
    chk_reg(SUB_GAIN_ONE, 8'hff);
    chk_reg(SUB_GAIN_TWO, 8'h00);
    wr(SUB_CTL_SECOND, 8'h02);
    chk_val(fe.ch2_gain, 9'h100, "gain two msb");
    chk_val(9'({fe.clamp_reference_select, fe.white_peak_enable, fe.agc_freeze}), 9'h002,
      "control bits clear");
    chk_val(9'({fe.ch1_gain_src, fe.ch2_gain_src}), 9'h003, "gain auto again");
    eq_pulse = 1'b1;
    @(negedge clk);
    chk_val(9'(agc_disable), 9'h001, "short window on");
    eq_pulse = 1'b0;
    @(negedge clk);
    chk_val(9'(agc_disable), 9'h000, "short window off");
    wr(SUB_CTL_SECOND, 8'h20);
    for (int f = 1; f >= 0; f--)
    begin
      f60 = !f[0];
      line_no = 10'd21;
      pre_eq = 1'b1;
      @(negedge clk);
      pre_eq = 1'b0;
      line_no = f[0] ? ACTIVE_LINE_60HZ : ACTIVE_LINE_50HZ;
      @(negedge clk);
      chk_val(9'(agc_disable), 9'h001, "long window held");
      f60 = f[0];
      line_no = f[0] ? ACTIVE_LINE_60HZ : ACTIVE_LINE_50HZ;
      @(negedge clk);
      chk_val(9'(agc_disable), 9'h000, "long window end");
    end
    complete_run();
  end
endmodule : video_input_frontend_control_test
